// file: rtl/tlih_map.svh
`ifndef TLIH_MAP_SVH
`define TLIH_MAP_SVH
`define TLIH_OFS_PEND_HIGH 12'h000
`define TLIH_OFS_PEND_MID 12'h004
`define TLIH_OFS_PEND_LOW 12'h008
`define TLIH_OFS_EN_HIGH 12'h00c
`define TLIH_OFS_EN_MID 12'h010
`define TLIH_OFS_EN_LOW 12'h014
`define TLIH_OFS_TOP_CODE 12'h018
`define TLIH_OFS_SUMMARY 12'h01c
`define TLIH_RST_PEND 8'h00
`define TLIH_RST_EN 8'h00
`define TLIH_CODE_NONE 8'hff
`define TLIH_SUM_HIGH_BIT 2
`define TLIH_SUM_MID_BIT 1
`define TLIH_SUM_LOW_BIT 0
`endif

// file: rtl/tlih_pkg.sv
package tlih_pkg;
   typedef struct packed {
      logic [7:0] high;
      logic [7:0] mid;
      logic [7:0] low;
   } tlih_levels_s;
   typedef enum logic [1:0] {
      TLIH_IDLE = 2'b00,
      TLIH_WRITE = 2'b01,
      TLIH_READ = 2'b10
   } tlih_phase_e;
endpackage

// file: rtl/tlih_handler.sv
// Added by the designer: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "tlih_map.svh"

// Operation
// - Twenty-four sources are taken in as three priority levels of eight each.
// - Every source passes a two-stage synchroniser on the system clock before edge detection.
// - A source that rises raises a stored request that holds until it is cleared.
// - High, mid and low levels drive request lines 0, 1 and 2 respectively.
// - A pending flag sets only on a rising sampled edge while its enable bit is 1.
// - Writing 1 to a pending bit clears it and writing 0 leaves it alone.
// - Reset clears every pending flag and every enable bit.
// - The top code gives the highest pending interrupt number, or all ones when none.
// - The summary shows high, mid and low pending on bits 2, 1 and 0, upper bits zero.
// - High flag bits 7 to 0 are interrupts 23 to 16.
// - Mid flag bits 7 to 0 are interrupts 15 to 8.
// - Low flag bits 7 to 0 are interrupts 7 to 0.
// - Enable registers map like the flags, 1 enables, and reset to zero.
module tlih_handler (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [11:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic [23:0] irq_src,
   output logic cpu_request_line_0,
   output logic cpu_request_line_1,
   output logic cpu_request_line_2
);

   ////////////////////////////////////////////////////////////////////////////
   logic [23:0] sync1_reg, sync2_reg, prev_reg;
   logic [23:0] sync1_next, sync2_next, prev_next;
   logic [23:0] rise;

   always_comb begin
      sync1_next = irq_src;
      sync2_next = sync1_reg;
      prev_next = sync2_reg;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync1_reg <= 24'h000000;
         sync2_reg <= 24'h000000;
         prev_reg <= 24'h000000;
      end else begin
         sync1_reg <= sync1_next;
         sync2_reg <= sync2_next;
         prev_reg <= prev_next;
      end
   end

   assign rise = sync2_reg & ~prev_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Bus address phase capture
   tlih_pkg::tlih_phase_e phase_reg, phase_next;
   logic [11:0] addr_reg, addr_next;

   always_comb begin
      phase_next = tlih_pkg::TLIH_IDLE;
      addr_next = addr_reg;
      if (hsel && hready && htrans[1]) begin
         phase_next = hwrite ? tlih_pkg::TLIH_WRITE : tlih_pkg::TLIH_READ;
         addr_next = haddr;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         phase_reg <= tlih_pkg::TLIH_IDLE;
         addr_reg <= 12'h000;
      end else begin
         phase_reg <= phase_next;
         addr_reg <= addr_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   tlih_pkg::tlih_levels_s pend_reg, pend_next, en_reg, en_next;
   tlih_pkg::tlih_levels_s clr;
   logic wr;

   always_comb begin
      wr = (phase_reg == tlih_pkg::TLIH_WRITE);
      clr = '0;
      en_next = en_reg;
      if (wr) begin
         case (addr_reg)
            `TLIH_OFS_PEND_HIGH: clr.high = hwdata[7:0];
            `TLIH_OFS_PEND_MID: clr.mid = hwdata[7:0];
            `TLIH_OFS_PEND_LOW: clr.low = hwdata[7:0];
            `TLIH_OFS_EN_HIGH: en_next.high = hwdata[7:0];
            `TLIH_OFS_EN_MID: en_next.mid = hwdata[7:0];
            `TLIH_OFS_EN_LOW: en_next.low = hwdata[7:0];
            default: clr = '0;
         endcase
      end
      // Set wins over a same-cycle clear so no edge is lost
      pend_next = (pend_reg & ~clr) | (rise & en_reg);
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pend_reg <= {3{`TLIH_RST_PEND}};
         en_reg <= {3{`TLIH_RST_EN}};
      end else begin
         pend_reg <= pend_next;
         en_reg <= en_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Code and summary are registered so a read sees a settled value
   logic [7:0] code_reg, code_next;
   logic [2:0] sum_reg, sum_next;

   always_comb begin
      code_next = `TLIH_CODE_NONE;
      for (int i = 0; i < 24; i++) begin
         if (pend_next[i]) begin
            code_next = 8'(i);
         end
      end
      sum_next = 3'h0;
      sum_next[`TLIH_SUM_HIGH_BIT] = |pend_next.high;
      sum_next[`TLIH_SUM_MID_BIT] = |pend_next.mid;
      sum_next[`TLIH_SUM_LOW_BIT] = |pend_next.low;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         code_reg <= `TLIH_CODE_NONE;
         sum_reg <= 3'h0;
         cpu_request_line_0 <= 1'b0;
         cpu_request_line_1 <= 1'b0;
         cpu_request_line_2 <= 1'b0;
      end else begin
         code_reg <= code_next;
         sum_reg <= sum_next;
         cpu_request_line_0 <= sum_next[`TLIH_SUM_HIGH_BIT];
         cpu_request_line_1 <= sum_next[`TLIH_SUM_MID_BIT];
         cpu_request_line_2 <= sum_next[`TLIH_SUM_LOW_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read data is registered at the address phase; zero wait states
   logic [31:0] rdata_next;

   always_comb begin
      rdata_next = 32'h00000000;
      if (hsel && hready && htrans[1] && !hwrite) begin
         case (haddr)
            `TLIH_OFS_PEND_HIGH: rdata_next[7:0] = pend_reg.high;
            `TLIH_OFS_PEND_MID: rdata_next[7:0] = pend_reg.mid;
            `TLIH_OFS_PEND_LOW: rdata_next[7:0] = pend_reg.low;
            `TLIH_OFS_EN_HIGH: rdata_next[7:0] = en_reg.high;
            `TLIH_OFS_EN_MID: rdata_next[7:0] = en_reg.mid;
            `TLIH_OFS_EN_LOW: rdata_next[7:0] = en_reg.low;
            `TLIH_OFS_TOP_CODE: rdata_next[7:0] = code_reg;
            `TLIH_OFS_SUMMARY: rdata_next[7:0] = {5'h00, sum_reg};
            default: rdata_next = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h00000000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hrdata <= rdata_next;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   sequence s_src_rise_en(int b);
      sync2_reg[b] && !prev_reg[b] && en_reg[b];
   endsequence

   property p_set_on_rise;
      @(posedge hclk) disable iff (!hresetn)
      s_src_rise_en(5) |=> pend_reg[5];
   endproperty
   a_set_on_rise: assert property (p_set_on_rise) else $error("flag not set");

   property p_no_set_disabled;
      @(posedge hclk) disable iff (!hresetn)
      (!en_reg[20] && !pend_reg[20]) |=> !pend_reg[20];
   endproperty
   a_no_set_disabled: assert property (p_no_set_disabled) else $error("disabled set");

   property p_w1c;
      @(posedge hclk) disable iff (!hresetn)
      (wr && addr_reg == `TLIH_OFS_PEND_MID && hwdata[3] && !(rise[11] && en_reg[11]))
         |=> !pend_reg[11];
   endproperty
   a_w1c: assert property (p_w1c) else $error("clear failed");

   property p_hold;
      @(posedge hclk) disable iff (!hresetn)
      (pend_reg[0] && !clr[0]) |=> pend_reg[0];
   endproperty
   a_hold: assert property (p_hold) else $error("flag lost");

   property p_line0;
      @(posedge hclk) disable iff (!hresetn)
      ##1 (cpu_request_line_0 == |pend_reg.high);
   endproperty
   a_line0: assert property (p_line0) else $error("line 0 wrong");

   property p_none_code;
      @(posedge hclk) disable iff (!hresetn)
      (pend_reg == '0) |-> (code_reg == `TLIH_CODE_NONE);
   endproperty
   a_none_code: assert property (p_none_code) else $error("code not ff");

   property p_top_wins;
      @(posedge hclk) disable iff (!hresetn)
      pend_reg[23] |-> (code_reg == 8'h17);
   endproperty
   a_top_wins: assert property (p_top_wins) else $error("priority wrong");

   property p_summary;
      @(posedge hclk) disable iff (!hresetn)
      sum_reg == {|pend_reg.high, |pend_reg.mid, |pend_reg.low};
   endproperty
   a_summary: assert property (p_summary) else $error("summary wrong");

   property p_sync_chain;
      @(posedge hclk) disable iff (!hresetn)
      $past(hresetn) |-> (sync1_reg == $past(irq_src)) && (sync2_reg == $past(sync1_reg))
         && (prev_reg == $past(sync2_reg));
   endproperty
   a_sync_chain: assert property (p_sync_chain) else $error("sync chain broken");

   property p_set_needs_edge;
      @(posedge hclk) disable iff (!hresetn)
      $past(hresetn) |-> ((24'(pend_reg) & ~$past(24'(pend_reg)) & ~$past(rise & en_reg))
         == 24'h000000);
   endproperty
   a_set_needs_edge: assert property (p_set_needs_edge) else $error("set without edge");

   property p_write0_keeps;
      @(posedge hclk) disable iff (!hresetn)
      (wr && (addr_reg == `TLIH_OFS_PEND_HIGH) && !hwdata[7] && pend_reg[23]) |=> pend_reg[23];
   endproperty
   a_write0_keeps: assert property (p_write0_keeps) else $error("flag lost on zero");

   property p_en_write;
      @(posedge hclk) disable iff (!hresetn)
      (wr && (addr_reg == `TLIH_OFS_EN_LOW)) |=> (en_reg.low == $past(hwdata[7:0]));
   endproperty
   a_en_write: assert property (p_en_write) else $error("enable not written");

   property p_line1;
      @(posedge hclk) disable iff (!hresetn)
      ##1 (cpu_request_line_1 == |pend_reg.mid);
   endproperty
   a_line1: assert property (p_line1) else $error("line 1 wrong");

   // Code must name a pending source with nothing pending above it
   sequence s_code_valid;
      (code_reg <= 8'h17) && pend_reg[code_reg[4:0]];
   endsequence

   sequence s_code_highest;
      ((24'(pend_reg) >> code_reg) >> 1) == 24'h000000;
   endsequence

   property p_code_is_top;
      @(posedge hclk) disable iff (!hresetn)
      (24'(pend_reg) != 24'h000000) |-> s_code_valid ##0 s_code_highest;
   endproperty
   a_code_is_top: assert property (p_code_is_top) else $error("code not highest");

   sequence s_clear_high_bit0;
      wr && (addr_reg == `TLIH_OFS_PEND_HIGH) && hwdata[0];
   endsequence

   // A clear colliding with a fresh edge must not swallow that edge
   property p_set_wins;
      @(posedge hclk) disable iff (!hresetn)
      s_clear_high_bit0 ##0 s_src_rise_en(16) |=> pend_reg[16];
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("edge lost to clear");

   sequence s_read_at(logic [11:0] a);
      hsel && hready && htrans[1] && !hwrite && (haddr == a);
   endsequence

   property p_read_high;
      @(posedge hclk) disable iff (!hresetn)
      s_read_at(`TLIH_OFS_PEND_HIGH) |=> (hrdata == {24'h000000, $past(pend_reg.high)});
   endproperty
   a_read_high: assert property (p_read_high) else $error("high read wrong");

   property p_read_mid;
      @(posedge hclk) disable iff (!hresetn)
      s_read_at(`TLIH_OFS_PEND_MID) |=> (hrdata == {24'h000000, $past(pend_reg.mid)});
   endproperty
   a_read_mid: assert property (p_read_mid) else $error("mid read wrong");

   property p_read_low;
      @(posedge hclk) disable iff (!hresetn)
      s_read_at(`TLIH_OFS_PEND_LOW) |=> (hrdata == {24'h000000, $past(pend_reg.low)});
   endproperty
   a_read_low: assert property (p_read_low) else $error("low read wrong");

endmodule
`default_nettype wire

// file: testbench/tlih_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module tlih_cpu_model (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [2:0] req,
   input wire logic clr,
   output logic [2:0] status
);
   ////////////////////////////////////////////////////////////////////////
   // Core status stays set after the request drops, until software clears it
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         status <= 3'h0;
      end else begin
         status <= (status & ~{3{clr}}) | req;
      end
   end
endmodule
`default_nettype wire

// file: testbench/tb_three_level_interrupt_handler.sv
`timescale 1ns/1ps
`default_nettype none
`include "tlih_map.svh"
module tb_three_level_interrupt_handler;
   logic hclk = 0;
   logic hresetn = 0;
   logic hsel = 0;
   logic hwrite = 0;
   logic clr = 0;
   logic [11:0] haddr = 12'h000;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic [31:0] rd;
   logic hreadyout;
   logic hresp;
   logic [23:0] irq_src = 24'h0;
   wire [2:0] lines;
   logic [2:0] status;
   int failures = 0;
   int num_checks = 0;
   int cyc = 0;
   always #50 hclk = ~hclk;
   tlih_handler DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .irq_src(irq_src), .cpu_request_line_0(lines[0]),
      .cpu_request_line_1(lines[1]), .cpu_request_line_2(lines[2]));
   tlih_cpu_model CPU (.hclk(hclk), .hresetn(hresetn), .req(lines), .clr(clr),
      .status(status));
   ////////////////////////////////////////////////////////////////////////
   task complete_run;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // A hang ends the run with a counted mismatch
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 8000) begin
         failures++;
         complete_run;
      end
   end
   task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      num_checks++;
      if (s !== e) begin
         failures++;
         $display("[FAIL] %s exp %h got %h", nm, e, s);
      end
   endtask
   task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'b10;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
      chk("okay", {31'h0, hresp}, 32'h0);
   endtask
   task rdc(input string nm, input logic [11:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(nm, rd, e);
   endtask
   task t_reset;
      for (int i = 0; i < 6; i++) rdc("flag_or_enable", 12'(4 * i), 32'h0);
      rdc("code", `TLIH_OFS_TOP_CODE, 32'hff);
      rdc("summary", `TLIH_OFS_SUMMARY, 32'h0);
      rdc("unmapped", 12'h020, 32'h0);
      chk("lines", {29'h0, lines}, 32'h0);
      $display("test reset done");
   endtask
   task t_map;
      int g;
      for (int i = 0; i < 3; i++) bus(1'b1, 12'(`TLIH_OFS_EN_HIGH + 4 * i), 32'hffffffff);
      for (int i = 0; i < 3; i++) rdc("enable", 12'(`TLIH_OFS_EN_HIGH + 4 * i), 32'hff);
      for (int i = 0; i < 24; i++) begin
         g = i / 8;
         @(posedge hclk);
         irq_src <= 24'h1 << i;
         repeat (6) @(posedge hclk);
         rdc("flag", 12'(8 - 4 * g), 32'h1 << (i % 8));
         rdc("code", `TLIH_OFS_TOP_CODE, 32'(i));
         rdc("summary", `TLIH_OFS_SUMMARY, 32'h1 << g);
         chk("lines", {29'h0, lines}, 32'h4 >> g);
         chk("core", {29'h0, status}, 32'h4 >> g);
         @(posedge hclk);
         irq_src <= 24'h0;
         bus(1'b1, 12'(8 - 4 * g), 32'h1 << (i % 8));
         clr <= 1'b1;
         @(posedge hclk);
         clr <= 1'b0;
         repeat (2) @(posedge hclk);
         rdc("cleared", 12'(8 - 4 * g), 32'h0);
         chk("core", {29'h0, status}, 32'h0);
      end
      $display("test map done");
   endtask
   task t_prio;
      bus(1'b1, `TLIH_OFS_EN_LOW, 32'h0);
      @(posedge hclk);
      irq_src <= 24'h808001;
      repeat (6) @(posedge hclk);
      rdc("disabled", `TLIH_OFS_PEND_LOW, 32'h0);
      rdc("code", `TLIH_OFS_TOP_CODE, 32'd23);
      rdc("summary", `TLIH_OFS_SUMMARY, 32'h6);
      bus(1'b1, `TLIH_OFS_PEND_HIGH, 32'h7f);
      rdc("write0", `TLIH_OFS_PEND_HIGH, 32'h80);
      bus(1'b1, `TLIH_OFS_PEND_HIGH, 32'h80);
      repeat (2) @(posedge hclk);
      rdc("code", `TLIH_OFS_TOP_CODE, 32'd15);
      // Re-raise source 16 so its edge meets a clear of the same bit
      @(posedge hclk);
      irq_src <= 24'h818001;
      repeat (6) @(posedge hclk);
      irq_src <= 24'h808001;
      repeat (4) @(posedge hclk);
      irq_src <= 24'h818001;
      bus(1'b1, `TLIH_OFS_PEND_HIGH, 32'h1);
      rdc("set_wins", `TLIH_OFS_PEND_HIGH, 32'h1);
      rdc("code", `TLIH_OFS_TOP_CODE, 32'd16);
      @(posedge hclk);
      irq_src <= 24'h0;
      hresetn <= 1'b0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      $display("test priority done");
      t_reset;
   endtask
   initial begin
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset;
      t_map;
      t_prio;
      complete_run;
   end
endmodule
`default_nettype wire
